/* src/tss_pkg.sv */
// constants and carrier types of the 128x128 time slot switch
// assumes a 200 MHz system clock and an 8 MHz bit clock from outside
`default_nettype none
package tss_pkg;
  // stream geometry: 4 streams, 32 channels, 2 falling bit-clock edges per bit
  localparam int         TSS_NSTR       = 4;
  localparam int         TSS_NCH        = 32;
  localparam int         TSS_CNT_W      = 9;
  localparam logic [3:0] TSS_STEP_LAST  = 4'hF;
  // host address map
  localparam int         TSS_ADDR_SEL   = 5;
  localparam logic [5:0] TSS_CTRL_OFS   = 6'h00;
  localparam logic [5:0] TSS_CHAN_OFS   = 6'h20;
  // switch_control fields
  localparam int         TSS_CTRL_SPLIT = 7;
  localparam int         TSS_CTRL_PE    = 6;
  localparam int         TSS_CTRL_MS    = 3;
  localparam int         TSS_CTRL_STA   = 0;
  localparam logic [7:0] TSS_CTRL_RST   = 8'h00;
  localparam logic [7:0] TSS_CTRL_MASK  = 8'hDB;
  // memory select codes
  localparam logic [1:0] TSS_MS_NONE    = 2'h0;
  localparam logic [1:0] TSS_MS_DATA    = 2'h1;
  localparam logic [1:0] TSS_MS_LOW     = 2'h2;
  localparam logic [1:0] TSS_MS_HIGH    = 2'h3;
  // channel_control_memory and source_or_payload_memory fields
  localparam int         TSS_CMH_PROC   = 2;
  localparam int         TSS_CMH_OE     = 0;
  localparam logic [7:0] TSS_CMH_MASK   = 8'h05;
  localparam logic [7:0] TSS_MEM_RST    = 8'h00;
  localparam int         TSS_CML_STR    = 5;
  localparam int         TSS_CML_CH     = 0;
  // per-stream half-bit steps: data memory commit and output fetch
  localparam logic [15:0] TSS_WR_STEP   = 16'h7640;
  localparam logic [15:0] TSS_FETCH_STEP = 16'h5320;
  // host access latency for everything but control writes
  localparam logic [2:0] TSS_HOST_WAIT  = 3'h3;
  // receive buffer shape
  localparam int         TSS_FIFO_D     = 8;

  typedef struct packed {
    logic [1:0] stream;
    logic [4:0] chan;
    logic [7:0] data;
  } tss_rx_word_t;

  localparam int TSS_FIFO_W = $bits(tss_rx_word_t);

  typedef struct packed {
    logic       strobe;
    logic       select_n;
    logic       read;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       bit_clk;
    logic       frame_n;
    logic [3:0] rx;
    logic       drive_en;
  } tss_pins_t;
endpackage : tss_pkg
`default_nettype wire

/* src/tss_switch.sv */
// time slot interchange switch: receive buffer and switch core
// assumes all pins asynchronous to i_sys_clk; pads resolve oe pairs
`default_nettype none

// synchronous fifo, width and depth as parameters
module tss_fifo
  import tss_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   fill;
  logic          push;
  logic          pop;

  // handshakes
  assign o_in_ready  = (fill != D[AW:0]);
  assign o_out_valid = (fill != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // pointers and fill level
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // storage
  always_ff @(posedge i_sys_clk) begin
    if (push) mem[wr_ptr] <= i_in_data;
  end
endmodule : tss_fifo

// switch core with host port and serial streams
module tss_switch
  import tss_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_serial_bit_clock,
  input  wire logic       i_frame_sync_in_n,
  input  wire logic [3:0] i_serial_in_streams,
  input  wire logic       i_master_drive_enable,
  output logic      [3:0] o_serial_out_streams,
  output logic      [3:0] o_serial_out_oe,
  input  wire logic       i_host_strobe,
  input  wire logic       i_host_select_n,
  input  wire logic       i_host_read,
  input  wire logic [5:0] i_host_address,
  input  wire logic [7:0] i_host_data_in,
  output logic      [7:0] o_host_data_out,
  output logic            o_host_data_oe,
  output logic            o_transfer_ack_n,
  output logic            o_transfer_ack_oe
);
  typedef enum logic [1:0] {
    TSS_HS_IDLE = 2'b00,
    TSS_HS_WAIT = 2'b01,
    TSS_HS_ACK  = 2'b10
  } tss_host_t;

  typedef struct packed {
    tss_pins_t           s1;
    tss_pins_t           s2;
    logic                clk_d;
    logic [8:0]          cnt;
    logic [3:0][7:0]     rx_sh;
    logic [3:0][7:0]     pend;
    logic [4:0]          pend_ch;
    logic [1:0]          pend_s;
    logic [2:0]          pend_n;
    logic [3:0][7:0]     tx_nx;
    logic [3:0]          en_nx;
    logic [3:0][7:0]     tx_sh;
    logic [3:0]          tx_en;
    logic [3:0]          tx_oe;
    logic [7:0]          ctrl;
    tss_host_t           hs;
    logic [2:0]          wait_n;
    logic [7:0]          rdata;
    logic                ack;
  } tss_state_t;

  tss_state_t st;
  tss_state_t next_st;

  logic [7:0] data_mem [128];
  logic [7:0] low_mem  [128];
  logic [1:0] high_mem [128];

  tss_pins_t    pins;
  logic         tick;
  logic         odd_half;
  logic [3:0]   step;
  logic [4:0]   next_ch;
  logic [3:0][7:0] fetch_byte;
  logic [3:0]   fetch_en;
  logic [3:0]   fetch_now;
  tss_rx_word_t push_word;
  logic         push_valid;
  logic         push_ready;
  tss_rx_word_t head;
  logic         head_valid;
  logic         head_ready;
  logic         host_go;
  logic         host_ctrl;
  logic [6:0]   host_idx;
  logic [1:0]   host_ms;
  logic         host_rd_dm;
  logic         do_acc;
  logic         we_low;
  logic         we_high;
  logic [7:0]   rd_val;

  assign pins = '{strobe: i_host_strobe, select_n: i_host_select_n,
                  read: i_host_read, addr: i_host_address,
                  wdata: i_host_data_in, bit_clk: i_serial_bit_clock,
                  frame_n: i_frame_sync_in_n, rx: i_serial_in_streams,
                  drive_en: i_master_drive_enable};

  // link timing from the second synchroniser stage only
  assign tick     = st.clk_d & ~st.s2.bit_clk;
  assign odd_half = st.cnt[0];
  assign step     = st.cnt[3:0];
  assign next_ch  = st.cnt[8:4] + 5'h01;

  // per output stream fetch of the channel after the current one
  for (genvar s = 0; s < TSS_NSTR; s++) begin : g_fetch
    logic [6:0] loc;
    logic [7:0] low;
    logic       proc;
    assign loc  = {2'(s), next_ch};
    assign low  = low_mem[loc];
    assign proc = st.ctrl[TSS_CTRL_PE] | high_mem[loc][1];
    // switched source from stream and channel fields
    assign fetch_byte[s] = proc ? low
                         : data_mem[{low[TSS_CML_STR+:2], low[TSS_CML_CH+:5]}];
    assign fetch_en[s]  = st.ctrl[TSS_CTRL_PE] | high_mem[loc][0];
    assign fetch_now[s] = tick & (step == TSS_FETCH_STEP[4*s+:4]);
  end

  // received bytes queue toward the data memory
  assign push_word  = '{stream: st.pend_s, chan: st.pend_ch,
                        data: st.pend[st.pend_s]};
  assign push_valid = (st.pend_n != 3'h0);

  tss_fifo #(
    .W (TSS_FIFO_W),
    .D (TSS_FIFO_D)
  ) u_rx_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_word),
    .o_out_valid (head_valid),
    .i_out_ready (head_ready),
    .o_out_data  (head)
  );

  // host decode from synchronised pins
  assign host_go    = st.s2.strobe & ~st.s2.select_n;
  assign host_ctrl  = ~st.s2.addr[TSS_ADDR_SEL];
  assign host_idx   = {st.ctrl[TSS_CTRL_STA+:2], st.s2.addr[4:0]};
  assign host_ms    = st.ctrl[TSS_CTRL_MS+:2];
  assign host_rd_dm = (st.hs == TSS_HS_WAIT) & st.s2.read & ~host_ctrl
                    & (st.ctrl[TSS_CTRL_SPLIT] | (host_ms == TSS_MS_DATA));

  // commit a queued byte once its stream's step has passed, not mid host data memory read
  assign head_ready = (step > TSS_WR_STEP[4*head.stream+:4]) & ~host_rd_dm;

  // memory access at the end of the wait
  assign do_acc  = (st.hs == TSS_HS_WAIT) & (st.wait_n == 3'h0) & host_go;
  assign we_low  = do_acc & ~st.s2.read & ~host_ctrl
                 & (st.ctrl[TSS_CTRL_SPLIT] | (host_ms == TSS_MS_LOW));
  assign we_high = do_acc & ~st.s2.read & ~host_ctrl
                 & ~st.ctrl[TSS_CTRL_SPLIT] & (host_ms == TSS_MS_HIGH);

  // read mux for the channel window and control register
  always_comb begin
    rd_val = TSS_MEM_RST;
    if (host_ctrl) begin
      rd_val = st.ctrl;
    end else if (st.ctrl[TSS_CTRL_SPLIT] || host_ms == TSS_MS_DATA) begin
      rd_val = data_mem[host_idx];
    end else if (host_ms == TSS_MS_LOW) begin
      rd_val = low_mem[host_idx];
    end else if (host_ms == TSS_MS_HIGH) begin
      rd_val = {5'h00, high_mem[host_idx][1], 1'b0, high_mem[host_idx][0]}
             & TSS_CMH_MASK;
    end
  end

  // next state of the whole core
  always_comb begin
    next_st       = st;
    next_st.s1    = pins;
    next_st.s2    = st.s1;
    next_st.clk_d = st.s2.bit_clk;

    // channel counter, reset by the frame pulse
    if (tick) begin
      if (!st.s2.frame_n) begin
        next_st.cnt = '0;
      end else begin
        next_st.cnt = st.cnt + 9'h001;
      end
    end

    // receive shifting, sampled mid bit
    if (tick && odd_half) begin
      for (int s = 0; s < TSS_NSTR; s++) begin
        next_st.rx_sh[s] = {st.rx_sh[s][6:0], st.s2.rx[s]};
      end
    end

    // hand queued bytes to the fifo, stalling while it is full
    if (push_valid && push_ready) begin
      next_st.pend_s = st.pend_s + 2'h1;
      next_st.pend_n = st.pend_n - 3'h1;
    end
    if (tick && step == TSS_STEP_LAST) begin
      for (int s = 0; s < TSS_NSTR; s++) begin
        next_st.pend[s] = {st.rx_sh[s][6:0], st.s2.rx[s]};
      end
      next_st.pend_ch = st.cnt[8:4];
      next_st.pend_s  = 2'h0;
      next_st.pend_n  = 3'h4;
    end

    // output fetch, load and shift
    for (int s = 0; s < TSS_NSTR; s++) begin
      if (fetch_now[s]) begin
        next_st.tx_nx[s] = fetch_byte[s];
        next_st.en_nx[s] = fetch_en[s];
      end
      if (tick && step == TSS_STEP_LAST) begin
        next_st.tx_sh[s] = st.tx_nx[s];
        next_st.tx_en[s] = st.en_nx[s];
      end else if (tick && odd_half) begin
        next_st.tx_sh[s] = {st.tx_sh[s][6:0], 1'b0};
      end
    end
    next_st.tx_oe = {4{st.s2.drive_en}} & st.tx_en;

    // host port sequencer
    unique case (st.hs)
      TSS_HS_IDLE: begin
        next_st.ack = 1'b0;
        if (host_go) begin
          if (host_ctrl && !st.s2.read) begin
            next_st.ctrl = st.s2.wdata & TSS_CTRL_MASK;
            next_st.hs   = TSS_HS_ACK;
            next_st.ack  = 1'b1;
          end else begin
            next_st.hs     = TSS_HS_WAIT;
            next_st.wait_n = TSS_HOST_WAIT;
          end
        end
      end
      TSS_HS_WAIT: begin
        if (!host_go) begin
          next_st.hs = TSS_HS_IDLE;
        end else if (st.wait_n != 3'h0) begin
          next_st.wait_n = st.wait_n - 3'h1;
        end else begin
          next_st.rdata = rd_val;
          next_st.hs    = TSS_HS_ACK;
          next_st.ack   = 1'b1;
        end
      end
      TSS_HS_ACK: begin
        if (!host_go) begin
          next_st.hs  = TSS_HS_IDLE;
          next_st.ack = 1'b0;
        end
      end
      default: begin
        next_st.hs  = TSS_HS_IDLE;
        next_st.ack = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st      <= '0;
      st.ctrl <= TSS_CTRL_RST;
      st.hs   <= TSS_HS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // memories: data from the fifo, connection halves from the host
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 128; i++) begin
        data_mem[i] <= TSS_MEM_RST;
        low_mem[i]  <= TSS_MEM_RST;
        high_mem[i] <= 2'h0;
      end
    end else begin
      if (head_valid && head_ready) begin
        data_mem[{head.stream, head.chan}] <= head.data;
      end
      if (we_low) begin
        low_mem[host_idx] <= st.s2.wdata;
      end
      if (we_high) begin
        high_mem[host_idx] <= {st.s2.wdata[TSS_CMH_PROC], st.s2.wdata[TSS_CMH_OE]};
      end
    end
  end

  // pins
  assign o_serial_out_streams = {st.tx_sh[3][7], st.tx_sh[2][7],
                                 st.tx_sh[1][7], st.tx_sh[0][7]};
  assign o_serial_out_oe      = st.tx_oe;
  assign o_host_data_out      = st.rdata;
  assign o_host_data_oe       = st.ack & st.s2.read;
  assign o_transfer_ack_n     = 1'b0;  // open drain pulls low only
  assign o_transfer_ack_oe    = st.ack;
endmodule : tss_switch
`default_nettype wire

/* dv/tss_switch_sva.sv */
// assertions on the ports of the time slot switch
// assumes binding onto tss_switch, one clock domain
`default_nettype none
module tss_switch_sva
  import tss_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       i_serial_bit_clock,
  input wire logic       i_frame_sync_in_n,
  input wire logic [3:0] i_serial_in_streams,
  input wire logic       i_master_drive_enable,
  input wire logic [3:0] o_serial_out_streams,
  input wire logic [3:0] o_serial_out_oe,
  input wire logic       i_host_strobe,
  input wire logic       i_host_select_n,
  input wire logic       i_host_read,
  input wire logic [5:0] i_host_address,
  input wire logic [7:0] i_host_data_in,
  input wire logic [7:0] o_host_data_out,
  input wire logic       o_host_data_oe,
  input wire logic       o_transfer_ack_n,
  input wire logic       o_transfer_ack_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // start of a host request at the pins
  sequence req_s;
    $rose(i_host_strobe) && !i_host_select_n;
  endsequence
  // acknowledge pin level and its release, data bus and serial enables, ack timing
  AST_ACK_LOW: assert property (o_transfer_ack_n == 1'b0)
    else $error("ack pin not driven low");
  AST_DESEL_IDLE: assert property (i_host_select_n [*5] |-> !o_transfer_ack_oe)
    else $error("ack while deselected");
  AST_STROBE_IDLE: assert property (!i_host_strobe [*5] |-> !o_transfer_ack_oe)
    else $error("ack without strobe");
  AST_WR_ONLY: assert property (!i_host_read [*4] |-> !o_host_data_oe)
    else $error("data bus driven on write");
  AST_DOE_IN_ACK: assert property (o_host_data_oe |-> o_transfer_ack_oe)
    else $error("data bus driven outside access");
  AST_ODE_OFF: assert property (!i_master_drive_enable [*4] |-> o_serial_out_oe == 4'h0)
    else $error("serial output driven with master enable low");
  AST_CTRL_FAST: assert property (req_s ##0 (!i_host_read && !i_host_address[5])
    |-> ##3 o_transfer_ack_oe)
    else $error("control write not acked in 3 cycles");
  AST_SLOW_ACK: assert property (req_s ##0 (i_host_read || i_host_address[5])
    |-> !o_transfer_ack_oe [*7] ##1 o_transfer_ack_oe)
    else $error("slow access ack timing wrong");
  AST_ACK_HOLD: assert property (o_transfer_ack_oe && i_host_strobe && !i_host_select_n
    |=> o_transfer_ack_oe)
    else $error("ack dropped during request");
  AST_RD_STABLE: assert property (o_host_data_oe && $past(o_host_data_oe)
    |-> $stable(o_host_data_out))
    else $error("read data moved while driven");
  // main scenarios
  COV_CTRL: cover property (req_s ##0 !i_host_read ##3 o_transfer_ack_oe);
  COV_READ: cover property (o_host_data_oe);
  COV_TX: cover property (o_serial_out_oe != 4'h0);
endmodule : tss_switch_sva
`default_nettype wire

/* dv/tss_peer.sv */
// serial stream peer: bit clock, frame pulse, receive bytes, transmit capture
// assumes bench reads cap[stream][chan] = {oe all bits, byte}
`default_nettype none
module tss_peer
  import tss_pkg::*;
(
  output logic            o_bit_clk,
  output logic            o_frame_n,
  output logic      [3:0] o_rx,
  input  wire logic [3:0] i_tx,
  input  wire logic [3:0] i_tx_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] cap [4][32];
  logic [8:0] p = 9'h1FF;
  logic [7:0] sh [4];
  logic [3:0] oe_ok;
  logic [7:0] b;
  // free running 125 ns bit clock, phase unrelated to system clock
  initial begin
    o_bit_clk = 1'b0;
    o_frame_n = 1'b1;
    o_rx      = 4'h0;
    #7;
    forever #62.5 o_bit_clk = ~o_bit_clk;
  end
  // tick counter, 512 ticks per frame
  always @(negedge o_bit_clk) p <= o_frame_n ? p + 9'd1 : 9'd0;
  // frame pulse, receive drive, transmit capture mid bit
  always @(posedge o_bit_clk) begin
    o_frame_n <= (p != 9'h1FF);
    for (int s = 0; s < 4; s++) begin
      if (p[0]) begin
        // bit of the slot the switch samples at the coming falling edge
        b = {1'b1, 2'(s), p[8:4]};
        o_rx[s] <= b[3'd7 - p[3:1]];
      end else begin
        sh[s] = {sh[s][6:0], i_tx[s]};
        oe_ok[s] = ((p[3:1] == 3'd0) ? 1'b1 : oe_ok[s]) & i_tx_oe[s];
        if (p[3:1] == 3'd7) cap[s][p[8:4]] = {oe_ok[s], sh[s]};
      end
    end
  end
endmodule : tss_peer
`default_nettype wire

/* dv/tss_switch_tb.sv */
// testbench of the time slot switch: host cycles and serial traffic
// assumes tss_peer and tss_switch_sva beside it
`default_nettype none
module tss_switch_tb;
  import tss_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       strobe = 1'b0;
  logic       sel_n = 1'b1;
  logic       rd_pin = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] hdrv = 8'h00;
  logic       hen = 1'b0;
  logic       master_drive_enable = 1'b0;
  wire  [3:0] tx, tx_oe, rx;
  wire  [7:0] dout;
  wire        doe, ackn, ackoe, bclk, fr;
  wire  [7:0] hd_wire = doe ? dout : (hen ? hdrv : ~hdrv);
  wire        ack_pin = ackoe ? ackn : 1'b1;
  int         n_fail = 0;
  int         checks_done = 0;
  always #2.5 clk = ~clk;
  tss_switch i_tss_switch (.i_sys_clk(clk), .i_rst(rst), .i_serial_bit_clock(bclk),
    .i_frame_sync_in_n(fr), .i_serial_in_streams(rx), .i_master_drive_enable(master_drive_enable),
    .o_serial_out_streams(tx), .o_serial_out_oe(tx_oe), .i_host_strobe(strobe),
    .i_host_select_n(sel_n), .i_host_read(rd_pin), .i_host_address(addr),
    .i_host_data_in(hd_wire), .o_host_data_out(dout), .o_host_data_oe(doe),
    .o_transfer_ack_n(ackn), .o_transfer_ack_oe(ackoe));
  tss_peer i_tss_peer (.o_bit_clk(bclk), .o_frame_n(fr), .o_rx(rx), .i_tx(tx),
    .i_tx_oe(tx_oe));
  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check
  // one host access, held until the acknowledge pin goes low
  task automatic host_acc(input logic r, input logic [5:0] a, input logic [7:0] wd,
                          output logic [7:0] d, output int lat);
    @(negedge clk);
    strobe = 1'b1;
    sel_n  = 1'b0;
    rd_pin = r;
    addr   = a;
    hdrv   = wd;
    hen    = !r;
    lat    = 0;
    while (ack_pin !== 1'b0 && lat < 50) begin
      @(negedge clk);
      lat++;
    end
    d      = hd_wire;
    // hold one more cycle so the standing acknowledge is seen held
    @(negedge clk);
    strobe = 1'b0;
    sel_n  = 1'b1;
    hen    = 1'b0;
    repeat (4) @(negedge clk);
  endtask : host_acc
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] d;
    int l;
    host_acc(1'b0, a, v, d, l);
    check(l == (a[5] ? 7 : 3), "write ack latency");
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    int l;
    host_acc(1'b1, a, 8'h00, d, l);
    check(d === e && l == 7, "read value or latency");
  endtask : rd
  task automatic conn(input logic [1:0] s, input logic [4:0] c, input logic [7:0] hi, lo);
    wr(6'h00, {6'h06, s});
    wr({1'b1, c}, hi);
    wr(6'h00, {6'h04, s});
    wr({1'b1, c}, lo);
  endtask : conn
  task automatic t_regs;
    wr(6'h00, 8'hFF);
    rd(6'h1F, 8'hDB);
  endtask : t_regs
  task automatic t_mem_sel;
    wr(6'h00, 8'h19);
    wr(6'h23, 8'hFF);
    rd(6'h23, 8'h05);
    wr(6'h00, 8'h11);
    wr(6'h23, 8'hC7);
    wr(6'h00, 8'h01);
    wr(6'h23, 8'h12);
    rd(6'h23, 8'h00);
    wr(6'h00, 8'h11);
    rd(6'h23, 8'hC7);
  endtask : t_mem_sel
  task automatic t_traffic;
    conn(2'd0, 5'd2, 8'h05, 8'h3C);
    conn(2'd1, 5'd4, 8'h01, 8'h49);
    conn(2'd2, 5'd4, 8'h01, 8'h49);
    conn(2'd3, 5'd6, 8'h00, 8'h21);
    master_drive_enable = 1'b1;
    repeat (26000) @(negedge clk);
    check(i_tss_peer.cap[0][2] === 9'h13C, "processor byte");
    check(i_tss_peer.cap[1][4] === 9'h1C9, "switched byte");
    check(i_tss_peer.cap[2][4] === 9'h1C9, "broadcast byte");
    check(i_tss_peer.cap[3][6][8] === 1'b0, "disabled channel");
    check(i_tss_peer.cap[0][5][8] === 1'b0, "unprogrammed channel");
    wr(6'h00, 8'h0A);
    rd(6'h29, 8'hC9);
  endtask : t_traffic
  task automatic t_split;
    wr(6'h00, 8'h81);
    rd(6'h24, 8'hA4);
    wr(6'h24, 8'h44);
    repeat (13500) @(negedge clk);
    check(i_tss_peer.cap[1][4] === 9'h1C4, "split write");
    check(i_tss_peer.cap[0][2] === 9'h13C, "byte resent");
  endtask : t_split
  task automatic t_override;
    wr(6'h00, 8'h40);
    repeat (13500) @(negedge clk);
    check(i_tss_peer.cap[3][6] === 9'h121, "override channel");
    check(i_tss_peer.cap[0][0][8] === 1'b1, "override enable");
  endtask : t_override
  task automatic t_ode;
    master_drive_enable = 1'b0;
    repeat (13500) @(negedge clk);
    check(i_tss_peer.cap[0][2][8] === 1'b0, "master disable");
  endtask : t_ode
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // watchdog over the whole run
  initial begin
    #460000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_mem_sel();
    t_traffic();
    t_split();
    t_override();
    t_ode();
    final_report();
  end
endmodule : tss_switch_tb
bind tss_switch tss_switch_sva i_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_serial_bit_clock(i_serial_bit_clock), .i_frame_sync_in_n(i_frame_sync_in_n),
  .i_serial_in_streams(i_serial_in_streams), .i_master_drive_enable(i_master_drive_enable),
  .o_serial_out_streams(o_serial_out_streams), .o_serial_out_oe(o_serial_out_oe),
  .i_host_strobe(i_host_strobe), .i_host_select_n(i_host_select_n),
  .i_host_read(i_host_read), .i_host_address(i_host_address),
  .i_host_data_in(i_host_data_in), .o_host_data_out(o_host_data_out),
  .o_host_data_oe(o_host_data_oe), .o_transfer_ack_n(o_transfer_ack_n),
  .o_transfer_ack_oe(o_transfer_ack_oe));
`default_nettype wire
